//--- design/eotl_gate.sv
// End-of-travel limit gate: command intake, limit evaluation, target gating
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "eotl_defs.svh"

module eotl_gate
    import eotl_pkg::*;
#(
    parameter int TGT_W = 32
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // APB
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Status words evaluated by the limits
    input  wire logic [15:0]      i_internal_status_word,
    input  wire logic [15:0]      i_second_internal_status_word,
    input  wire logic [15:0]      i_extended_io_word,
    // Trajectory update request
    input  wire logic             i_tgt_valid,
    input  wire logic [TGT_W-1:0] i_tgt_next,
    input  wire logic             i_move_profile,
    output logic      [TGT_W-1:0] o_target,
    output logic                  o_tgt_blocked,
    output logic                  o_neg_limit,
    output logic                  o_pos_limit
);

    // Target is compared as a signed value; one bit leaves no sign room
    if (TGT_W < 2 || TGT_W > 32) begin : g_bad_width
        $error("TGT_W must be 2..32");
    end

    // The packet counter must reach the last parameter word
    if (`EOTL_NUM_PARAMS != 3'h6) begin : g_bad_params
        $error("six mask words expected per packet");
    end

    // Code word plus parameters must make up one packet
    if (`EOTL_CMD_WORDS != `EOTL_NUM_PARAMS + 3'h1) begin : g_bad_packet
        $error("packet length does not match parameter count");
    end

    // ------------------------------------------------------------
    // Mask storage: [pair*2 + (0 enable, 1 state)]
    // ------------------------------------------------------------
    eotl_word_t neg_mask_q [6];
    eotl_word_t pos_mask_q [6];
    eotl_word_t shadow_q [6];
    logic [7:0] cmd_code_q;
    logic [2:0] word_cnt_q;
    eotl_rx_e   rx_state_q;
    logic       bad_cmd_q;
    logic       drop_neg_q;
    logic       drop_pos_q;

    logic       apb_wr;
    logic       apb_rd;
    logic       cmd_start;
    logic       cmd_word;
    logic       cmd_commit;
    logic       commit_neg;

    assign apb_wr = psel && penable && pwrite && pready;
    assign apb_rd = psel && !penable && !pwrite;
    assign cmd_start = apb_wr && (paddr == `EOTL_ADDR_CMD_CTRL);
    assign cmd_word  = apb_wr && (paddr == `EOTL_ADDR_CMD_DATA) && (rx_state_q == EOTL_COLLECT);
    assign cmd_commit = cmd_word && (word_cnt_q == `EOTL_NUM_PARAMS - 3'h1);
    assign commit_neg = (cmd_code_q == `EOTL_CMD_NEG);

    // ------------------------------------------------------------
    // Command intake: code word then six parameters
    // ------------------------------------------------------------
    logic code_known;
    logic cmd_abort;

    // Only the two limit codes are served here
    assign code_known = (pwdata[7:0] == `EOTL_CMD_NEG) || (pwdata[7:0] == `EOTL_CMD_POS); // R9 R10
    // A new code word aborts a partial packet
    assign cmd_abort  = cmd_start && (rx_state_q == EOTL_COLLECT);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rx_state_q <= EOTL_IDLE;
        end else begin
            case (rx_state_q)
                EOTL_IDLE: begin
                    if (cmd_start && code_known) begin
                        rx_state_q <= EOTL_COLLECT;
                    end
                end
                EOTL_COLLECT: begin
                    if (cmd_start || cmd_commit) begin
                        rx_state_q <= EOTL_IDLE;
                    end
                end
                default: begin
                    rx_state_q <= EOTL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cmd_code_q <= 8'h00;
        end else if (cmd_start && rx_state_q == EOTL_IDLE) begin
            cmd_code_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            word_cnt_q <= 3'h0;
        end else if (cmd_start && rx_state_q == EOTL_IDLE) begin
            word_cnt_q <= 3'h0;
        end else if (cmd_word) begin
            word_cnt_q <= word_cnt_q + 3'h1;
        end
    end

    // Flag stays until the next code word, so software can poll it
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            bad_cmd_q <= 1'b0;
        end else if (cmd_abort) begin
            bad_cmd_q <= 1'b1;
        end else if (cmd_start) begin
            bad_cmd_q <= !code_known;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int k = 0; k < 6; k++) begin
                shadow_q[k] <= `EOTL_MASK_RESET;
            end
        end else if (cmd_word) begin
            shadow_q[word_cnt_q] <= pwdata[15:0];
        end
    end

    // Shadow keeps the live set untouched until the last word lands; the
    // sixth word comes straight from the bus so all six change on one edge
    eotl_word_t new_set [6];
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            new_set[k] = shadow_q[k];
        end
        new_set[5] = pwdata[15:0];
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int k = 0; k < 6; k++) begin
                neg_mask_q[k] <= `EOTL_MASK_RESET; // R11
            end
        end else if (cmd_commit && commit_neg) begin
            for (int k = 0; k < 6; k++) begin
                neg_mask_q[k] <= new_set[k]; // R12
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int k = 0; k < 6; k++) begin
                pos_mask_q[k] <= `EOTL_MASK_RESET; // R11
            end
        end else if (cmd_commit && !commit_neg) begin
            for (int k = 0; k < 6; k++) begin
                pos_mask_q[k] <= new_set[k]; // R12
            end
        end
    end

    // ------------------------------------------------------------
    // Limit evaluation
    // ------------------------------------------------------------
    // Evaluated straight from the live inputs; the registered copies on the
    // outputs trail them by one cycle
    eotl_word_t status_in [3];
    eotl_word_t mask_v    [2][6];
    eotl_word_t pair_act  [2][3];
    logic [2:0] pair_hit  [2];
    logic [1:0] lim_hit;

    assign status_in[0] = i_internal_status_word;
    assign status_in[1] = i_second_internal_status_word;
    assign status_in[2] = i_extended_io_word;

    always_comb begin
        for (int k = 0; k < 6; k++) begin
            mask_v[0][k] = neg_mask_q[k];
            mask_v[1][k] = pos_mask_q[k];
        end
    end

    always_comb begin
        for (int l = 0; l < 2; l++) begin
            for (int p = 0; p < 3; p++) begin
                // A bit counts only when enabled and at its chosen level
                pair_act[l][p] = mask_v[l][2 * p] & ~(status_in[p] ^ mask_v[l][2 * p + 1]); // R1 R2
                pair_hit[l][p] = |pair_act[l][p]; // R3
            end
            lim_hit[l] = |pair_hit[l];
        end
    end

    // ------------------------------------------------------------
    // Target gating
    // ------------------------------------------------------------
    logic                    dec_req;
    logic                    inc_req;
    logic                    block_now;
    logic signed [TGT_W-1:0] tgt_next_s;
    logic signed [TGT_W-1:0] tgt_cur_s;
    assign tgt_next_s = i_tgt_next;
    assign tgt_cur_s  = o_target;
    // Equal values are neither direction and always pass
    assign dec_req   = i_tgt_valid && (tgt_next_s < tgt_cur_s);
    assign inc_req   = i_tgt_valid && (tgt_next_s > tgt_cur_s);
    assign block_now = (dec_req && lim_hit[0]) || (inc_req && lim_hit[1]); // R4 R8

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_neg_limit <= 1'b0;
            o_pos_limit <= 1'b0;
        end else begin
            o_neg_limit <= lim_hit[0];
            o_pos_limit <= lim_hit[1];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_tgt_blocked <= 1'b0;
        end else begin
            o_tgt_blocked <= block_now;
        end
    end

    // Blocked updates are dropped, not queued: any move type just stops
    // advancing; a profile keeps issuing and resumes when the limit clears
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_target <= '0;
        end else if (i_tgt_valid && !block_now) begin
            o_target <= i_tgt_next; // R5 R6 R7
        end
    end

    // Sticky drop flags; set wins over a read clear
    logic status_rd;
    assign status_rd = psel && penable && !pwrite && (paddr == `EOTL_ADDR_STATUS);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            drop_neg_q <= 1'b0;
        end else begin
            drop_neg_q <= (dec_req && lim_hit[0]) || (drop_neg_q && !status_rd); // R6
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            drop_pos_q <= 1'b0;
        end else begin
            drop_pos_q <= (inc_req && lim_hit[1]) || (drop_pos_q && !status_rd); // R6
        end
    end

    // ------------------------------------------------------------
    // APB slave: no wait states, data ready in access phase
    // ------------------------------------------------------------
    logic [2:0]  addr_slot;
    logic        addr_ok;
    logic        addr_neg_mask;
    logic        addr_pos_mask;
    logic        addr_status;
    logic        addr_cmd;
    logic [31:0] status_word;
    logic [31:0] rd_d;
    logic        hit;

    assign addr_slot     = paddr[4:2];
    assign addr_ok       = (paddr[1:0] == 2'h0) && (addr_slot < 3'h6);
    assign addr_neg_mask = (paddr[11:5] == 7'h00) && addr_ok;
    assign addr_pos_mask = (paddr[11:5] == 7'h01) && addr_ok;
    assign addr_status   = (paddr == `EOTL_ADDR_STATUS);
    assign addr_cmd      = (paddr == `EOTL_ADDR_CMD_DATA) || (paddr == `EOTL_ADDR_CMD_CTRL);
    assign hit           = addr_neg_mask || addr_pos_mask || addr_status || addr_cmd;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`EOTL_STAT_NEG_BIT]      = lim_hit[0];
        status_word[`EOTL_STAT_POS_BIT]      = lim_hit[1];
        status_word[`EOTL_STAT_BUSY_BIT]     = (rx_state_q == EOTL_COLLECT);
        status_word[`EOTL_STAT_BADCMD_BIT]   = bad_cmd_q;
        status_word[`EOTL_STAT_DROP_NEG_BIT] = drop_neg_q;
        status_word[`EOTL_STAT_DROP_POS_BIT] = drop_pos_q;
    end

    // Command ports and unmapped space read as zero
    always_comb begin
        rd_d = 32'h0000_0000;
        if (addr_neg_mask) begin
            rd_d = {16'h0000, neg_mask_q[addr_slot]};
        end else if (addr_pos_mask) begin
            rd_d = {16'h0000, pos_mask_q[addr_slot]};
        end else if (addr_status) begin
            rd_d = status_word;
        end
    end

    // The answer is built during setup, so the access phase always ends
    // on its first edge
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !hit;
        end
    end

    // Read data is captured in setup, before the drop flags clear in access
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            prdata <= rd_d;
        end
    end

endmodule
`default_nettype wire

//--- design/eotl_defs.svh
// Constants for the end-of-travel limit gate
// ------------------------------------------------------------
// How it works
// R1 - Enable bit 1 selects status bit for checking
// R2 - Enabled bit active when level equals state bit
// R3 - Three mask pairs: status, status2, extended io
// R4 - Negative limit active rejects target decreases
// R5 - Negative limit alone still allows increases
// R6 - Velocity/time moves stop advancing when blocked
// R7 - Profile moves continue, blocked updates suppressed
// R8 - Positive limit mirrors negative, blocks increases
// R9 - Negative config command code 67, seven words
// R10 - Positive config command code 66, same layout
// R11 - Reset clears all enable masks
// R12 - Six masks of one limit update together
// ------------------------------------------------------------
`ifndef EOTL_DEFS_SVH
`define EOTL_DEFS_SVH

`define EOTL_CMD_NEG        8'h43
`define EOTL_CMD_POS        8'h42
`define EOTL_CMD_WORDS      3'h7
`define EOTL_NUM_PARAMS     3'h6
`define EOTL_MASK_RESET     16'h0000

`define EOTL_ADDR_NEG_BASE  12'h000
`define EOTL_ADDR_POS_BASE  12'h020
`define EOTL_ADDR_STATUS    12'h040
`define EOTL_ADDR_CMD_DATA  12'h044
`define EOTL_ADDR_CMD_CTRL  12'h048

`define EOTL_STAT_NEG_BIT   0
`define EOTL_STAT_POS_BIT   1
`define EOTL_STAT_BUSY_BIT  2
`define EOTL_STAT_BADCMD_BIT 3
`define EOTL_STAT_DROP_NEG_BIT 4
`define EOTL_STAT_DROP_POS_BIT 5

`endif

//--- design/eotl_pkg.sv
// Types for the end-of-travel limit gate
package eotl_pkg;
    typedef enum {
        EOTL_IDLE,
        EOTL_COLLECT
    } eotl_rx_e;

    typedef logic [15:0] eotl_word_t;
endpackage

//--- verification/eotl_gate_assertions.sv
// Port assertions for the limit gate
`timescale 1ns/1ps
`default_nettype none
module eotl_gate_assertions #(parameter int TGT_W = 32) (
    input wire logic             i_mclk, i_rst, pready, pwrite, psel, penable, pslverr,
    input wire logic             i_tgt_valid, o_tgt_blocked, o_neg_limit, o_pos_limit,
    input wire logic [15:0]      i_internal_status_word, i_second_internal_status_word, i_extended_io_word,
    input wire logic [TGT_W-1:0] i_tgt_next, o_target
);
    logic [47:0] sw_q, sw;
    logic        wr_q, ok, dn, up;
    always_ff @(posedge i_mclk) sw_q <= sw;
    always_ff @(posedge i_mclk) wr_q <= pready & pwrite;
    assign sw = {i_internal_status_word, i_second_internal_status_word, i_extended_io_word};
    // Limit outputs lag a cycle, so trust them only while inputs and masks hold
    assign ok = !wr_q && sw_q == sw && i_tgt_valid;
    assign dn = $signed(i_tgt_next) < $signed(o_target);
    assign up = $signed(i_tgt_next) > $signed(o_target);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_rst_clears: assert property ($fell(i_rst) |-> !o_neg_limit && !o_pos_limit && o_target == '0)
        else $error("reset left output");
    a_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("no pready");
    a_err_ack: assert property (pslverr |-> pready) else $error("lone pslverr");
    a_neg_block: assert property (ok && o_neg_limit && dn |=> o_tgt_blocked && $stable(o_target))
        else $error("decrease passed");
    a_pos_block: assert property (ok && o_pos_limit && up |=> o_tgt_blocked && $stable(o_target))
        else $error("increase passed");
    a_inc_pass: assert property (ok && !o_pos_limit && !dn |=> o_target == $past(i_tgt_next))
        else $error("increase dropped");
    a_dec_pass: assert property (ok && !o_neg_limit && !up |=> o_target == $past(i_tgt_next))
        else $error("decrease dropped");
    a_idle_hold: assert property (!i_tgt_valid |=> !o_tgt_blocked && $stable(o_target))
        else $error("target moved");
    c_neg: cover property (ok && o_neg_limit && dn);
    c_pos: cover property (ok && o_pos_limit && up);
    c_err: cover property (pslverr);
endmodule
`default_nettype wire

//--- verification/eotl_host_model.sv
// Host model: APB transfers and limit command packets
`timescale 1ns/1ps
`default_nettype none
`include "eotl_defs.svh"
module eotl_host_model (
    input  wire logic        i_mclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    logic to = 1'b0;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge i_mclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge i_mclk);
        penable <= 1'b1;
        for (n = 0; n < 9 && !pready; n++) @(posedge i_mclk);
        if (n == 9) to = 1'b1;
        r = prdata;
        e = pslverr;
        // Released lines show a changed value, not a stale copy
        {psel, penable, paddr, pwdata} <= {2'b0, ~a, ~d};
    endtask
    task automatic cmd(logic [7:0] c, logic [15:0] m [6]);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, `EOTL_ADDR_CMD_CTRL, {24'h0, c}, r, e);
        foreach (m[i]) xfer(1'b1, `EOTL_ADDR_CMD_DATA, {16'h0, m[i]}, r, e);
    endtask
endmodule
`default_nettype wire

//--- verification/eotl_gate_tb.sv
// Self-checking bench for the end-of-travel limit gate
`timescale 1ns/1ps
`default_nettype none
`include "eotl_defs.svh"
module eotl_gate_tb;
    logic        i_mclk, i_rst, psel, penable, pwrite, pready, pslverr, tv, mp, nl, pl, bo, chk, e, en, ep, eb, dneg, dpos;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, tn, tgo;
    logic [15:0] sw [3], m [6], mk [2][6];
    int          tg, n_errors, total_checks, seed;
    eotl_gate dut (.i_mclk, .i_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .i_internal_status_word(sw[0]), .i_second_internal_status_word(sw[1]), .i_extended_io_word(sw[2]),
        .i_tgt_valid(tv), .i_tgt_next(tn), .i_move_profile(mp), .o_target(tgo), .o_tgt_blocked(bo),
        .o_neg_limit(nl), .o_pos_limit(pl));
    eotl_host_model host (.i_mclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
    task automatic check(string s, logic [31:0] a, x);
        total_checks++;
        if (a !== x) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", s, x, a);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic lim(int d);
        lim = 1'b0;
        for (int i = 0; i < 3; i++) lim |= |(mk[d][2 * i] & ~(sw[i] ^ mk[d][2 * i + 1]));
    endfunction
    always @(posedge host.to) begin
        n_errors++;
        results();
    end
    // Reference model: gate each request with limits seen at the same edge
    always @(posedge i_mclk) begin
        if (chk) begin
            en = lim(0);
            ep = lim(1);
            eb = tv && (($signed(tn) < tg && en) || ($signed(tn) > tg && ep));
            if (tv && $signed(tn) < tg && en) dneg = 1'b1;
            if (tv && $signed(tn) > tg && ep) dpos = 1'b1;
            if (tv && !eb) tg = tn;
            #1;
            check("neg_limit", 32'(nl), 32'(en));
            check("pos_limit", 32'(pl), 32'(ep));
            check("blocked", 32'(bo), 32'(eb));
            check("target", tgo, tg);
        end
    end
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        seed = 32'h8166e4a4;
        {i_rst, tv, mp, chk} = 4'h8;
        tn = '0;
        sw = '{default: '0};
        mk = '{default: '0};
        {tg, n_errors, total_checks} = '0;
        {dneg, dpos} = 2'b0;
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            host.xfer(1'b0, 12'(i * 4 + i / 6 * 8), '0, r, e);
            check("reg_reset", r, '0);
        end
        host.xfer(1'b1, 12'h000, '1, r, e);
        host.xfer(1'b0, 12'h100, '0, r, e);
        check("slverr", 32'(e), 32'h1);
        check("unmapped", r, '0);
        host.xfer(1'b0, 12'h000, '0, r, e);
        check("ro_mask", r, '0);
        host.xfer(1'b1, `EOTL_ADDR_CMD_CTRL, 32'h44, r, e);
        host.xfer(1'b0, `EOTL_ADDR_STATUS, '0, r, e);
        check("bad_code", r & 32'h8, 32'h8);
        host.xfer(1'b1, `EOTL_ADDR_CMD_CTRL, {24'h0, `EOTL_CMD_NEG}, r, e);
        host.xfer(1'b1, `EOTL_ADDR_CMD_DATA, 32'hffff, r, e);
        host.xfer(1'b1, `EOTL_ADDR_CMD_CTRL, {24'h0, `EOTL_CMD_NEG}, r, e);
        host.xfer(1'b0, `EOTL_ADDR_STATUS, '0, r, e);
        check("abort", r & 32'hc, 32'h8);
        host.xfer(1'b0, 12'h000, '0, r, e);
        check("abort_mask", r, '0);
        for (int k = 0; k < 6; k++) begin
            foreach (m[i]) m[i] = 16'($random(seed));
            foreach (sw[i]) m[2 * i] = (i == k % 3) ? 16'h1 << 4'($random(seed)) : 16'h0;
            host.cmd(k % 2 ? `EOTL_CMD_POS : `EOTL_CMD_NEG, m);
            mk[k % 2] = m;
            foreach (m[i]) begin
                host.xfer(1'b0, 12'(k % 2 * 32 + i * 4), '0, r, e);
                check("mask", r, {16'h0, m[i]});
            end
            chk = 1'b1;
            repeat (80) begin
                @(posedge i_mclk);
                tv <= 1'($random(seed));
                mp <= 1'($random(seed));
                tn <= tgo + 32'($random(seed) % 3);
                if (($random(seed) & 3) == 0) sw[k % 3] <= 16'($random(seed));
            end
            @(posedge i_mclk);
            tv <= 1'b0;
            repeat (2) @(posedge i_mclk);
            chk = 1'b0;
            host.xfer(1'b0, `EOTL_ADDR_STATUS, '0, r, e);
            check("drop_flags", r & 32'h30, {26'h0, dpos, dneg, 4'h0});
            {dneg, dpos} = 2'b0;
        end
        results();
    end
endmodule
bind eotl_gate eotl_gate_assertions #(.TGT_W(TGT_W)) u_chk (.*);
`default_nettype wire
